// ---- rtl/rftr_defs.svh ----
`ifndef RFTR_DEFS_SVH
`define RFTR_DEFS_SVH

`define RFTR_OFS_COARSE 12'h120
`define RFTR_OFS_SHAPE 12'h128
`define RFTR_OFS_TEST 12'h1fc
`define RFTR_OFS_PHASE 12'h208

`define RFTR_WMASK_COARSE 32'h0000007f
`define RFTR_WMASK_SHAPE 32'h1f020fff
`define RFTR_WMASK_TEST 32'h07ffffdf
`define RFTR_WMASK_PHASE 32'h0f373773

`define RFTR_NVMASK_COARSE 32'h00000078
`define RFTR_NVMASK_SHAPE 32'h00000000
`define RFTR_NVMASK_TEST 32'h00000000
`define RFTR_NVMASK_PHASE 32'h00373770

`define RFTR_RST_COARSE 32'h00000000
`define RFTR_RST_SHAPE 32'h00000000
`define RFTR_RST_TEST 32'h0050000a
`define RFTR_RST_PHASE 32'h00000000

`define RFTR_RESID_MSB 28
`define RFTR_RESID_LSB 24
`define RFTR_BYPASS_BIT 17
`define RFTR_SLEW_MSB 11
`define RFTR_SLEW_LSB 8
`define RFTR_FALL_MSB 7
`define RFTR_FALL_LSB 4
`define RFTR_RISE_MSB 3
`define RFTR_RISE_LSB 0
`define RFTR_ILOAD_MSB 22
`define RFTR_ILOAD_LSB 19
`define RFTR_CREF_BIT 0
`define RFTR_SIGN_BIT 27
`define RFTR_FINE_MSB 26
`define RFTR_FINE_LSB 24
`define RFTR_COARSE_MSB 2
`define RFTR_COARSE_LSB 0

`define RFTR_FINE_DEG 10'sd5
`define RFTR_COARSE_DEG 10'sd45

`endif

// ---- rtl/rftr_pkg.sv ----
package rftr_pkg;
  typedef logic [31:0] rftr_word_t;
  typedef enum logic [2:0] {
    RFTR_SEL_NONE = 3'b000,
    RFTR_SEL_SHAPE = 3'b001,
    RFTR_SEL_TEST = 3'b010,
    RFTR_SEL_PHASE = 3'b011,
    RFTR_SEL_COARSE = 3'b100
  } rftr_reg_sel_t;
endpackage

// ---- rtl/rftr_field_reg.sv ----
`timescale 1ns/1ps
module rftr_field_reg #(
  parameter logic [31:0] RST_VAL = 32'h0000_0000,
  parameter logic [31:0] WMASK = 32'hffff_ffff,
  parameter logic [31:0] NVMASK = 32'h0000_0000
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic wrEn,
  input wire rftr_pkg::rftr_word_t wrData,
  input wire logic ldEn,
  input wire rftr_pkg::rftr_word_t ldData,
  output rftr_pkg::rftr_word_t q
);
  import rftr_pkg::*;

  rftr_word_t q_r;
  rftr_word_t q_nxt;
  wire rftr_word_t ldMerged = (q_r & ~NVMASK) | (ldData & NVMASK);

  // Software write wins over a default load in the same cycle
  assign q_nxt = wrEn ? (wrData & WMASK) : (ldEn ? ldMerged : q_r);
  assign q = q_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q_r <= RST_VAL & WMASK;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule

// ---- rtl/rftr_regs.sv ----
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`include "rftr_defs.svh"

// Notes on behaviour
// - Shape register holds 5-bit residual carrier level for overshoot prevention.
// - One read-write bit bypasses switched-capacitor shaping; resets to zero.
// - Four-bit read-write shunt regulator slew setting, reset zero.
// - Four-bit read-write falling edge time constant, reset zero.
// - Four-bit read-write rising edge time constant, reset zero.
// - Edge time constants act only while shaping bypass is set.
// - Test register holds four-bit load-current setting, reset ten.
// - Test bit zero set references carrier to transmitter supply; reset zero.
// - Sign bit picks fine offset direction: zero positive, one negative.
// - Three-bit fine phase adds five degrees per code; zero disables.
// - Internal fields are software written or loaded from stored defaults.
// - Coarse phase is a three-bit code in 45-degree steps.
module rftr_regs #(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire rftr_pkg::rftr_word_t pwdata,
  output rftr_pkg::rftr_word_t prdata,
  output logic pready,
  output logic pslverr,
  input wire logic nvmLoad,
  input wire rftr_pkg::rftr_word_t nvmCoarseWord,
  input wire rftr_pkg::rftr_word_t nvmPhaseWord,
  output logic [4:0] residual_carrier_level,
  output logic shaping_bypass,
  output logic [3:0] shunt_slew_setting,
  output logic [3:0] fall_edge_time_const,
  output logic [3:0] rise_edge_time_const,
  output logic [3:0] load_current_setting,
  output logic carrier_ref_select,
  output logic fine_phase_sign,
  output logic [2:0] fine_phase_step,
  output logic [2:0] coarse_phase_step,
  output logic [9:0] phaseOffsetDeg
);
  import rftr_pkg::*;

  // The decode slices the low twelve address bits
  if (ADDR_WIDTH < 12 || ADDR_WIDTH > 32) begin : gWidthCheck
    $error("rftr_regs: ADDR_WIDTH must be 12 to 32");
  end

  function automatic rftr_reg_sel_t decodeSel(input logic [ADDR_WIDTH-1:0] addr);
    logic [ADDR_WIDTH-1:0] hiZero;
    hiZero = addr >> 12;
    decodeSel = RFTR_SEL_NONE;
    if (hiZero == '0) begin
      case (addr[11:0])
        `RFTR_OFS_SHAPE: decodeSel = RFTR_SEL_SHAPE;
        `RFTR_OFS_TEST: decodeSel = RFTR_SEL_TEST;
        `RFTR_OFS_PHASE: decodeSel = RFTR_SEL_PHASE;
        `RFTR_OFS_COARSE: decodeSel = RFTR_SEL_COARSE;
        default: decodeSel = RFTR_SEL_NONE;
      endcase
    end
  endfunction

  // Bus phase decode
  wire logic setupPhase = psel & ~penable;
  wire logic accessDone = psel & penable & pready;
  wire logic writeDone = accessDone & pwrite;
  wire rftr_reg_sel_t curSel = decodeSel(paddr);
  wire logic mapped = (curSel != RFTR_SEL_NONE);

  wire logic wrShape = writeDone & (curSel == RFTR_SEL_SHAPE);
  wire logic wrTest = writeDone & (curSel == RFTR_SEL_TEST);
  wire logic wrPhase = writeDone & (curSel == RFTR_SEL_PHASE);
  wire logic wrCoarse = writeDone & (curSel == RFTR_SEL_COARSE);

  rftr_word_t shapeQ;
  rftr_word_t testQ;
  rftr_word_t phaseQ;
  rftr_word_t coarseQ;

  // Reserved read-only bits are cleared by the write masks
  rftr_field_reg #(
    .RST_VAL(`RFTR_RST_SHAPE),
    .WMASK(`RFTR_WMASK_SHAPE),
    .NVMASK(`RFTR_NVMASK_SHAPE)
  ) uShape (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .wrEn(wrShape),
    .wrData(pwdata),
    .ldEn(1'b0),
    .ldData(32'h0000_0000),
    .q(shapeQ)
  );

  rftr_field_reg #(
    .RST_VAL(`RFTR_RST_TEST),
    .WMASK(`RFTR_WMASK_TEST),
    .NVMASK(`RFTR_NVMASK_TEST)
  ) uTest (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .wrEn(wrTest),
    .wrData(pwdata),
    .ldEn(1'b0),
    .ldData(32'h0000_0000),
    .q(testQ)
  );

  rftr_field_reg #(
    .RST_VAL(`RFTR_RST_PHASE),
    .WMASK(`RFTR_WMASK_PHASE),
    .NVMASK(`RFTR_NVMASK_PHASE)
  ) uPhase (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .wrEn(wrPhase),
    .wrData(pwdata),
    .ldEn(nvmLoad),
    .ldData(nvmPhaseWord),
    .q(phaseQ)
  );

  rftr_field_reg #(
    .RST_VAL(`RFTR_RST_COARSE),
    .WMASK(`RFTR_WMASK_COARSE),
    .NVMASK(`RFTR_NVMASK_COARSE)
  ) uCoarse (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .wrEn(wrCoarse),
    .wrData(pwdata),
    .ldEn(nvmLoad),
    .ldData(nvmCoarseWord),
    .q(coarseQ)
  );

  wire rftr_word_t readMux =
    (curSel == RFTR_SEL_SHAPE) ? shapeQ :
    (curSel == RFTR_SEL_TEST) ? testQ :
    (curSel == RFTR_SEL_PHASE) ? phaseQ :
    (curSel == RFTR_SEL_COARSE) ? coarseQ : 32'h0000_0000;

  // Field slices straight off the register flops
  assign residual_carrier_level = shapeQ[`RFTR_RESID_MSB:`RFTR_RESID_LSB];
  assign shaping_bypass = shapeQ[`RFTR_BYPASS_BIT];
  assign shunt_slew_setting = shapeQ[`RFTR_SLEW_MSB:`RFTR_SLEW_LSB];
  assign load_current_setting = testQ[`RFTR_ILOAD_MSB:`RFTR_ILOAD_LSB];
  assign carrier_ref_select = testQ[`RFTR_CREF_BIT];
  assign fine_phase_sign = phaseQ[`RFTR_SIGN_BIT];
  assign fine_phase_step = phaseQ[`RFTR_FINE_MSB:`RFTR_FINE_LSB];
  assign coarse_phase_step = coarseQ[`RFTR_COARSE_MSB:`RFTR_COARSE_LSB];

  // Time constants reach the analog side only under bypass; one cycle late
  wire logic [3:0] fallNxt = shaping_bypass ? shapeQ[`RFTR_FALL_MSB:`RFTR_FALL_LSB] : 4'h0;
  wire logic [3:0] riseNxt = shaping_bypass ? shapeQ[`RFTR_RISE_MSB:`RFTR_RISE_LSB] : 4'h0;

  // Combined phase: coarse steps plus signed fine steps, degrees
  wire logic signed [9:0] coarseDeg = $signed({7'h00, coarse_phase_step}) * `RFTR_COARSE_DEG;
  wire logic signed [9:0] fineDeg = $signed({7'h00, fine_phase_step}) * `RFTR_FINE_DEG;
  wire logic signed [9:0] phaseNxt = fine_phase_sign ? (coarseDeg - fineDeg)
                                                     : (coarseDeg + fineDeg);

  logic [3:0] fall_r;
  logic [3:0] rise_r;
  logic [9:0] phase_r;
  rftr_word_t prdata_r;
  logic pready_r;
  logic pslverr_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fall_r <= 4'h0;
      rise_r <= 4'h0;
      phase_r <= 10'h000;
    end else begin
      fall_r <= fallNxt;
      rise_r <= riseNxt;
      phase_r <= phaseNxt;
    end
  end

  // Answer in the first access cycle; reads are captured at setup
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setupPhase;
      pslverr_r <= setupPhase & ~mapped;
      if (setupPhase) begin
        prdata_r <= pwrite ? 32'h0000_0000 : readMux;
      end
    end
  end

  assign fall_edge_time_const = fall_r;
  assign rise_edge_time_const = rise_r;
  assign phaseOffsetDeg = phase_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  sequence setupRead;
    psel && !penable && !pwrite;
  endsequence

  sequence accessEnd;
    psel && penable && pready;
  endsequence

  resid_write_a: assert property (
    wrShape |=> residual_carrier_level == $past(pwdata[28:24]))
    else $error("residual level not taken from write");

  bypass_write_a: assert property (
    wrShape |=> shaping_bypass == $past(pwdata[17]))
    else $error("bypass bit not taken from write");

  slew_write_a: assert property (
    wrShape |=> shunt_slew_setting == $past(pwdata[11:8]))
    else $error("slew setting not taken from write");

  fall_gate_a: assert property (
    shaping_bypass |=> fall_edge_time_const == $past(shapeQ[7:4]))
    else $error("falling time constant not passed under bypass");

  rise_gate_a: assert property (
    shaping_bypass |=> rise_edge_time_const == $past(shapeQ[3:0]))
    else $error("rising time constant not passed under bypass");

  tau_ignored_a: assert property (
    !shaping_bypass |=> fall_edge_time_const == 4'h0 && rise_edge_time_const == 4'h0)
    else $error("time constants leak without bypass");

  iload_hold_a: assert property (
    !wrTest |=> $stable(load_current_setting))
    else $error("load current changed without a write");

  cref_write_a: assert property (
    wrTest |=> carrier_ref_select == $past(pwdata[0]))
    else $error("carrier reference bit not taken from write");

  phase_sum_a: assert property (
    ##1 $signed(phaseOffsetDeg) == $signed({7'h00, $past(coarse_phase_step)}) * 10'sd45
      + ($past(fine_phase_sign) ? -10'sd5 : 10'sd5)
      * $signed({7'h00, $past(fine_phase_step)}))
    else $error("combined phase offset wrong");

  fine_zero_a: assert property (
    fine_phase_step == 3'h0 |=> phaseOffsetDeg == 10'($past(coarse_phase_step) * 45))
    else $error("fine code zero still offsets phase");

  nvm_load_a: assert property (
    nvmLoad && !wrPhase |=> (phaseQ & 32'h00373770) == ($past(nvmPhaseWord) & 32'h00373770))
    else $error("internal fields not loaded from defaults");

  reserved_zero_a: assert property (
    setupRead ##1 accessEnd |-> (prdata & 32'he0fdf000) == 32'h0 || $past(curSel) != RFTR_SEL_SHAPE)
    else $error("reserved shape bits read non-zero");

  answer_time_a: assert property (
    setupRead |=> pready ##1 !pready)
    else $error("access not answered in one cycle");

  unmapped_error_a: assert property (
    setupPhase && !mapped |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  write_wins_a: assert property (
    wrPhase |=> phaseQ == ($past(pwdata) & `RFTR_WMASK_PHASE))
    else $error("phase write lost against default load");

  coarse_write_a: assert property (
    wrCoarse |=> coarse_phase_step == $past(pwdata[2:0]))
    else $error("coarse phase not taken from write");

  fine_write_a: assert property (
    wrPhase |=> fine_phase_step == $past(pwdata[26:24]) && fine_phase_sign == $past(pwdata[27]))
    else $error("fine phase fields not taken from write");

  iload_write_a: assert property (
    wrTest |=> load_current_setting == $past(pwdata[22:19]))
    else $error("load current not taken from write");
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin numChecks++; if ((gt) !== (ex)) begin failures++; \
  $display("[ERR] %s expected %h seen %h", nm, (ex), (gt)); end end
module tb;
  import rftr_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, nvmLoad = 1'b0;
  logic [11:0] paddr = 12'h000;
  rftr_word_t pwdata = 32'h0, nvmCoarseWord = 32'h0, nvmPhaseWord = 32'h0;
  rftr_word_t prdata;
  logic pready, pslverr, shaping_bypass, carrier_ref_select, fine_phase_sign;
  logic [4:0] residual_carrier_level;
  logic [3:0] shunt_slew_setting, fall_edge_time_const, rise_edge_time_const;
  logic [3:0] load_current_setting;
  logic [2:0] fine_phase_step, coarse_phase_step;
  logic [9:0] phaseOffsetDeg;
  int failures = 0, numChecks = 0;
  logic [31:0] seed = 32'hd0f4e3cc;
  // Order: coarse, shape, test, phase
  logic [11:0] ofs [4] = '{12'h120, 12'h128, 12'h1fc, 12'h208};
  rftr_word_t wm [4] = '{32'h0000007f, 32'h1f020fff, 32'h07ffffdf, 32'h0f373773};
  rftr_word_t nv [4] = '{32'h00000078, 32'h0, 32'h0, 32'h00373770};
  rftr_word_t mdl [4];

  always #5 ref_clk = ~ref_clk;

  rftr_regs rftr_regs_i (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nvmLoad(nvmLoad), .nvmCoarseWord(nvmCoarseWord),
    .nvmPhaseWord(nvmPhaseWord), .residual_carrier_level(residual_carrier_level),
    .shaping_bypass(shaping_bypass), .shunt_slew_setting(shunt_slew_setting),
    .fall_edge_time_const(fall_edge_time_const), .rise_edge_time_const(rise_edge_time_const),
    .load_current_setting(load_current_setting), .carrier_ref_select(carrier_ref_select),
    .fine_phase_sign(fine_phase_sign), .fine_phase_step(fine_phase_step),
    .coarse_phase_step(coarse_phase_step), .phaseOffsetDeg(phaseOffsetDeg));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [9:0] expOff(input logic [2:0] c, input logic s, input logic [2:0] f);
    int v;
    v = int'(c) * 45 + (s ? -int'(f) * 5 : int'(f) * 5);
    return v[9:0];
  endfunction

  task automatic results;
    $display("checks %0d mismatches %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // No wait-state count assumed; only the watchdog cuts a hang
  task automatic apb(input logic w, input logic [11:0] a, input rftr_word_t d,
                     output rftr_word_t r, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input int i, input rftr_word_t d);
    rftr_word_t r;
    logic e;
    apb(1'b1, ofs[i], d, r, e);
    mdl[i] = d & wm[i];
    `CHK("wr_err", 1'b0, e)
  endtask

  task automatic checkAll;
    rftr_word_t r;
    logic e;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("resid", mdl[1][28:24], residual_carrier_level)
    `CHK("bypass", mdl[1][17], shaping_bypass)
    `CHK("slew", mdl[1][11:8], shunt_slew_setting)
    `CHK("fall", mdl[1][17] ? mdl[1][7:4] : 4'h0, fall_edge_time_const)
    `CHK("rise", mdl[1][17] ? mdl[1][3:0] : 4'h0, rise_edge_time_const)
    `CHK("iload", mdl[2][22:19], load_current_setting)
    `CHK("cref", mdl[2][0], carrier_ref_select)
    `CHK("sign", mdl[3][27], fine_phase_sign)
    `CHK("fine", mdl[3][26:24], fine_phase_step)
    `CHK("coarse", mdl[0][2:0], coarse_phase_step)
    `CHK("offset", expOff(mdl[0][2:0], mdl[3][27], mdl[3][26:24]), phaseOffsetDeg)
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ofs[i], 32'h0, r, e);
      `CHK("rd", mdl[i], r)
    end
  endtask

  task automatic doReset;
    rst_b <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    mdl = '{32'h0, 32'h0, 32'h0050000a, 32'h0};
  endtask

  initial begin
    rftr_word_t r;
    logic e;
    doReset();
    checkAll();
    for (int i = 0; i < 4; i++) wr(i, (i == 3) ? 32'hfcffffff : 32'hffffffff);
    checkAll();
    // Every coarse and sign code, fine codes kept to 0..4, other bits random
    for (int k = 0; k < 128; k++) begin
      seed = lfsr(seed);
      wr(0, {seed[31:3], k[2:0]});
      seed = lfsr(seed);
      wr(3, {seed[31:28], k[6], 3'((k >> 3) % 5), seed[23:0]});
      seed = lfsr(seed);
      wr(1, seed);
      seed = lfsr(seed);
      wr(2, seed);
      checkAll();
    end
    apb(1'b1, 12'h124, 32'hffffffff, r, e);
    `CHK("unm_werr", 1'b1, e)
    apb(1'b0, 12'h124, 32'h0, r, e);
    `CHK("unm_rerr", 1'b1, e)
    `CHK("unm_data", 32'h0, r)
    checkAll();
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      seed = lfsr(seed);
      nvmCoarseWord <= seed;
      mdl[0] = (mdl[0] & ~nv[0]) | (seed & nv[0]);
      seed = lfsr(seed);
      nvmPhaseWord <= seed;
      mdl[3] = (mdl[3] & ~nv[3]) | (seed & nv[3]);
      nvmLoad <= 1'b1;
      @(posedge ref_clk);
      nvmLoad <= 1'b0;
      checkAll();
    end
    // Reset again in mid-run
    @(posedge ref_clk);
    doReset();
    checkAll();
    results();
  end

  initial begin
    #500us;
    failures++;
    results();
  end
endmodule
